// *** vmac_pkg.sv ***
// Constants, types and field layouts of the vector multiply unit.
// Assumes one core clock; shared by the unit top and its lane datapath.
// Function
// RQ1: Opcode upper bits zero means multiply class
// RQ2: Element field picks vector or broadcast element
// RQ3: Second operand is vector or broadcast scalar
// RQ4: Accumulate bit adds, else round and load
// RQ5: Signed 32-bit product, 48-bit lane accumulator
// RQ6: Format 000 doubles, rounds, signed clamp b31-16
// RQ7: Format 001 same but unsigned clamp
// RQ8: Fraction formats differ only in clamp signedness
// RQ9: Format 011 quantize shift, round, mask
// RQ10: Quantize accumulate oddifies, ignoring both operands
// RQ11: Rounding adds operand by accumulator sign
// RQ12: Register number field one shifts addend 16
// RQ13: Format 100 unsigned, shift right, low slice
// RQ14: Format 101 signed by unsigned, high slice
// RQ15: Format 110 unsigned by signed, low slice
// RQ16: Format 111 signed, shift left 16, high
// RQ17: Rounding constant goes into accumulator only
// RQ18: Clamp tests upper bits, substitutes limits
// RQ19: Software follows load with accumulate multiply
// RQ20: Eight lanes compute product plus round, shift
// RQ21: Formats give low, middle, high partial products
// RQ22: Software keeps double operands in register pairs
// RQ23: All eight lanes update as one operation
package vmac_pkg;

	// Datapath shape
	localparam int LANES = 8;
	localparam int EW    = 16;
	localparam int ACC_W = 48;
	localparam int VEC_W = LANES * EW;

	// Opcode fields
	localparam logic [1:0] CLASS_MUL  = 2'h0;
	localparam int         OP_ACC_BIT = 3;
	localparam logic [3:0] ELEM_VEC   = 4'h0;
	localparam logic [4:0] SRC1_ONE   = 5'h01;

	// Multiply formats
	typedef enum logic [2:0] {
		FMT_FRAC   = 3'b000,
		FMT_FRAC_U = 3'b001,
		FMT_RND    = 3'b010,
		FMT_QUANT  = 3'b011,
		FMT_LOW    = 3'b100,
		FMT_MID_SU = 3'b101,
		FMT_MID_US = 3'b110,
		FMT_HIGH   = 3'b111
	} vmac_fmt_type;

	// Shift, round and clamp figures
	localparam int          SH_FRAC     = 1;
	localparam int          SH_WIDE     = 16;
	localparam int          RES_LSB_HI  = 16;
	localparam int          RES_LSB_LO  = 0;
	localparam int          RES_LSB_Q   = 17;
	localparam int          CLAMP_MSB   = 31;
	localparam int          CLAMP_MSB_Q = 32;
	localparam int          ODD_BIT     = 21;
	localparam logic [47:0] ROUND_FRAC  = 48'h0000_0000_8000;
	localparam logic [47:0] ROUND_QUANT = 48'h0000_001f_0000;
	localparam logic [47:0] ODD_STEP    = 48'h0000_0020_0000;
	localparam logic [15:0] QUANT_MASK  = 16'hfff0;
	localparam logic [15:0] S_MAX       = 16'h7fff;
	localparam logic [15:0] S_MIN       = 16'h8000;
	localparam logic [15:0] U_MAX       = 16'hffff;
	localparam logic [15:0] U_MIN       = 16'h0000;

	// Register map on the AXI4-Lite slave
	localparam int          ADDR_W      = 8;
	localparam logic [7:0]  REG_CTRL    = 8'h00;
	localparam logic [7:0]  REG_STATUS  = 8'h04;
	localparam int          CTRL_EN_BIT = 0;
	localparam logic [31:0] CTRL_RESET  = 32'h0000_0001;
	localparam int          STAT_OP_LSB = 16;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// Decoded instruction from the issue stage
	typedef struct packed {
		logic [5:0] opcode;
		logic [3:0] element;
		logic [4:0] second_source_reg;
		logic [4:0] first_source_reg;
		logic [4:0] dest_vector_reg;
	} vmac_instr_type;

	// Write-back to the vector register file
	typedef struct packed {
		logic [4:0]   dest_vector_reg;
		logic [127:0] data;
	} vmac_wb_type;

endpackage

// *** vmac_lane.sv ***
// One vector_lane_unit: multiply, accumulate, round and clamp.
// Purely combinational; the unit top holds the accumulator flops.
`timescale 1ns/1ns
module vmac_lane
(
	// Instruction controls
	input  wire logic [2:0]  fmt_i,
	input  wire logic        acc_mode_i,
	input  wire logic        src1_one_i,
	// Operands and accumulator
	input  wire logic [15:0] s_i,
	input  wire logic [15:0] t_i,
	input  wire logic [47:0] acc_i,
	// Results
	output logic      [47:0] next_acc_o,
	output logic      [15:0] res_o
);

	// Signed clamp: bits from msb up must all match
	function automatic logic [15:0] sat_s(input logic [47:0] a,
		input int msb, input int lsb);
		logic signed [47:0] hi;
		hi = $signed(a) >>> msb;
		if (hi == 48'sh0 || hi == -48'sh1)
			sat_s = a[lsb +: 16];
		else
			sat_s = a[47] ? vmac_pkg::S_MIN : vmac_pkg::S_MAX;
	endfunction

	logic               s_sgn;
	logic               t_sgn;
	logic signed [33:0] prod;
	logic signed [47:0] prod_w;
	logic signed [47:0] shifted;
	logic        [47:0] round;
	logic        [47:0] addend;
	logic               acc_neg;
	logic               acc_pos;

	// Operand signedness and product per format
	always_comb
	begin
		s_sgn = !(fmt_i == vmac_pkg::FMT_LOW || fmt_i == vmac_pkg::FMT_MID_US);
		t_sgn = !(fmt_i == vmac_pkg::FMT_LOW || fmt_i == vmac_pkg::FMT_MID_SU);
		prod = $signed({s_sgn & s_i[15], s_i}) * $signed({t_sgn & t_i[15], t_i}); // RQ5
		prod_w = 48'(prod);
		case (fmt_i)
			vmac_pkg::FMT_FRAC, vmac_pkg::FMT_FRAC_U:
				shifted = prod_w <<< vmac_pkg::SH_FRAC; // RQ6
			vmac_pkg::FMT_QUANT, vmac_pkg::FMT_HIGH:
				shifted = prod_w <<< vmac_pkg::SH_WIDE; // RQ16
			vmac_pkg::FMT_LOW:
				shifted = prod_w >>> vmac_pkg::SH_WIDE; // RQ13
			default:
				shifted = prod_w; // RQ14 RQ15
		endcase
	end

	// Round value and accumulator update
	always_comb
	begin
		acc_neg = acc_i[47];
		acc_pos = !acc_i[47] && acc_i != 48'h0;
		case (fmt_i)
			vmac_pkg::FMT_FRAC, vmac_pkg::FMT_FRAC_U:
				round = vmac_pkg::ROUND_FRAC; // RQ8
			vmac_pkg::FMT_QUANT:
				round = prod[33] ? vmac_pkg::ROUND_QUANT : 48'h0; // RQ9
			default:
				round = 48'h0;
		endcase
		addend = src1_one_i ? {{16{t_i[15]}}, t_i, 16'h0} // RQ12
			: {{32{t_i[15]}}, t_i};
		if (fmt_i == vmac_pkg::FMT_RND)
		begin
			// Minus variant on a set accumulate bit
			if (acc_mode_i ? acc_neg : acc_pos) // RQ11
				next_acc_o = acc_i + addend;
			else
				next_acc_o = acc_i;
		end
		else if (fmt_i == vmac_pkg::FMT_QUANT && acc_mode_i)
		begin
			// Oddify; operands ignored, near-zero accumulators left alone
			if (acc_i[vmac_pkg::ODD_BIT] ||
				acc_i[vmac_pkg::ACC_W-1:vmac_pkg::ODD_BIT] == '0) // RQ10
				next_acc_o = acc_i;
			else if (acc_neg)
				next_acc_o = acc_i + vmac_pkg::ODD_STEP;
			else
				next_acc_o = acc_i - vmac_pkg::ODD_STEP;
		end
		else if (acc_mode_i)
			next_acc_o = acc_i + 48'(shifted); // RQ4 RQ20
		else
			next_acc_o = 48'(shifted) + round; // RQ4 RQ17
	end

	// Slice selection and saturation of the new accumulator
	always_comb
	begin
		case (fmt_i)
			vmac_pkg::FMT_FRAC_U:
				if (next_acc_o[47]) // RQ7
					res_o = vmac_pkg::U_MIN;
				else if (next_acc_o[47:32] != 16'h0)
					res_o = vmac_pkg::U_MAX;
				else
					res_o = next_acc_o[31:16];
			vmac_pkg::FMT_QUANT:
				res_o = sat_s(next_acc_o, vmac_pkg::CLAMP_MSB_Q,
					vmac_pkg::RES_LSB_Q) & vmac_pkg::QUANT_MASK; // RQ9
			vmac_pkg::FMT_LOW, vmac_pkg::FMT_MID_US:
				res_o = sat_s(next_acc_o, vmac_pkg::CLAMP_MSB,
					vmac_pkg::RES_LSB_LO); // RQ18 RQ21
			default:
				res_o = sat_s(next_acc_o, vmac_pkg::CLAMP_MSB,
					vmac_pkg::RES_LSB_HI); // RQ18 RQ21
		endcase
	end

endmodule

// *** vmac_unit.sv ***
// Eight-lane vector multiply unit with its accumulators and a small
// AXI4-Lite control slave. Issue port driven by same-clock decode logic;
// write-back goes to the vector register file one cycle after issue.
`timescale 1ns/1ns
module vmac_unit
(
	// Clock and reset
	input  wire logic                     ref_clk_i,
	input  wire logic                     rst_i,
	// Instruction issue
	input  wire logic                     issue_valid_i,
	input  wire vmac_pkg::vmac_instr_type issue_instr_i,
	input  wire logic [127:0]             first_source_i,
	input  wire logic [127:0]             second_source_i,
	// Register file write-back
	output logic                          wb_valid_o,
	output vmac_pkg::vmac_wb_type         wb_o,
	// AXI4-Lite write address and data
	input  wire logic                     s_axi_awvalid_i,
	output logic                          s_axi_awready_o,
	input  wire logic [7:0]               s_axi_awaddr_i,
	input  wire logic                     s_axi_wvalid_i,
	output logic                          s_axi_wready_o,
	input  wire logic [31:0]              s_axi_wdata_i,
	input  wire logic [3:0]               s_axi_wstrb_i,
	// AXI4-Lite write response
	output logic                          s_axi_bvalid_o,
	input  wire logic                     s_axi_bready_i,
	output logic [1:0]                    s_axi_bresp_o,
	// AXI4-Lite read
	input  wire logic                     s_axi_arvalid_i,
	output logic                          s_axi_arready_o,
	input  wire logic [7:0]               s_axi_araddr_i,
	output logic                          s_axi_rvalid_o,
	input  wire logic                     s_axi_rready_i,
	output logic [31:0]                   s_axi_rdata_o,
	output logic [1:0]                    s_axi_rresp_o
);

	// Broadcast element index for one lane
	function automatic logic [2:0] elem_lane(input logic [3:0] e,
		input logic [2:0] lane);
		if (e[3])
			elem_lane = e[2:0];
		else if (e[2])
			elem_lane = {lane[2], e[1:0]};
		else if (e[1])
			elem_lane = {lane[2:1], e[0]};
		else
			elem_lane = lane;
	endfunction

	// Control and status
	logic        unit_en;
	logic [15:0] mul_count;
	logic [5:0]  last_opcode;

	// AXI4-Lite bookkeeping
	logic [7:0]  wr_addr;
	logic [31:0] wr_data;
	logic [3:0]  wr_strb;
	logic        aw_held;
	logic        w_held;

	// Lane datapath
	logic [47:0]  acc_q [vmac_pkg::LANES];
	logic [47:0]  lane_next [vmac_pkg::LANES];
	logic [15:0]  lane_res [vmac_pkg::LANES];
	logic [127:0] res_vec;
	logic         is_mul;
	logic         fire;

	// Multiply class: top two opcode bits clear
	assign is_mul = issue_instr_i.opcode[5:4] == vmac_pkg::CLASS_MUL; // RQ1
	assign fire   = issue_valid_i && unit_en && is_mul;

	// Eight lanes side by side; element 0 in the low half-word
	for (genvar i = 0; i < vmac_pkg::LANES; i++)
	begin : g_lane
		logic [2:0] t_sel;

		// Full vector or broadcast scalar of the second source
		assign t_sel = elem_lane(issue_instr_i.element, 3'(i)); // RQ2 RQ3

		vmac_lane u_lane
		(
			.fmt_i      (issue_instr_i.opcode[2:0]),
			.acc_mode_i (issue_instr_i.opcode[vmac_pkg::OP_ACC_BIT]),
			.src1_one_i (issue_instr_i.first_source_reg ==
				vmac_pkg::SRC1_ONE),
			.s_i        (first_source_i[i*16 +: 16]),
			.t_i        (second_source_i[{t_sel, 4'h0} +: 16]),
			.acc_i      (acc_q[i]),
			.next_acc_o (lane_next[i]),
			.res_o      (lane_res[i])
		);

		assign res_vec[i*16 +: 16] = lane_res[i];
	end

	// Accumulators: all lanes commit together on a multiply
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			for (int k = 0; k < vmac_pkg::LANES; k++)
				acc_q[k] <= 48'h0;
		end
		else if (fire)
		begin
			for (int k = 0; k < vmac_pkg::LANES; k++)
				acc_q[k] <= lane_next[k]; // RQ23
		end
	end

	// Write-back of the clamped slice, one cycle after issue
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			wb_valid_o <= 1'b0;
			wb_o       <= '0;
		end
		else
		begin
			wb_valid_o <= fire; // RQ23
			if (fire)
			begin
				wb_o.dest_vector_reg <= issue_instr_i.dest_vector_reg;
				wb_o.data            <= res_vec;
			end
		end
	end

	// Status counters; wraps silently at 16 bits
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			mul_count   <= 16'h0;
			last_opcode <= 6'h0;
		end
		else if (fire)
		begin
			mul_count   <= mul_count + 16'h1;
			last_opcode <= issue_instr_i.opcode;
		end
	end

	// Write address and data taken in either order
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			s_axi_awready_o <= 1'b0;
			s_axi_wready_o  <= 1'b0;
			aw_held         <= 1'b0;
			w_held          <= 1'b0;
			wr_addr         <= 8'h0;
			wr_data         <= 32'h0;
			wr_strb         <= 4'h0;
		end
		else
		begin
			// Each ready only while its own channel holds nothing and no response is pending
			s_axi_awready_o <= !aw_held && !s_axi_bvalid_o &&
				!(s_axi_awvalid_i && s_axi_awready_o);
			s_axi_wready_o  <= !w_held && !s_axi_bvalid_o &&
				!(s_axi_wvalid_i && s_axi_wready_o);
			if (s_axi_awvalid_i && s_axi_awready_o)
			begin
				aw_held <= 1'b1;
				wr_addr <= s_axi_awaddr_i;
			end
			if (s_axi_wvalid_i && s_axi_wready_o)
			begin
				w_held  <= 1'b1;
				wr_data <= s_axi_wdata_i;
				wr_strb <= s_axi_wstrb_i;
			end
			if (aw_held && w_held)
			begin
				aw_held <= 1'b0;
				w_held  <= 1'b0;
			end
		end
	end

	// Register commit and write response
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			unit_en        <= vmac_pkg::CTRL_RESET[vmac_pkg::CTRL_EN_BIT];
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o  <= vmac_pkg::RESP_OKAY;
		end
		else
		begin
			if (aw_held && w_held)
			begin
				s_axi_bvalid_o <= 1'b1;
				if (wr_addr == vmac_pkg::REG_CTRL)
				begin
					s_axi_bresp_o <= vmac_pkg::RESP_OKAY;
					if (wr_strb[0])
						unit_en <= wr_data[vmac_pkg::CTRL_EN_BIT];
				end
				else
					s_axi_bresp_o <= vmac_pkg::RESP_SLVERR; // Status is read-only
			end
			else if (s_axi_bvalid_o && s_axi_bready_i)
				s_axi_bvalid_o <= 1'b0;
		end
	end

	// Read channel: one read in flight, answered the cycle after it is taken
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o  <= 1'b0;
			s_axi_rdata_o   <= 32'h0;
			s_axi_rresp_o   <= vmac_pkg::RESP_OKAY;
		end
		else if (s_axi_arvalid_i && s_axi_arready_o)
		begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o  <= 1'b1;
			s_axi_rresp_o   <= vmac_pkg::RESP_OKAY;
			case (s_axi_araddr_i)
				vmac_pkg::REG_CTRL:
					s_axi_rdata_o <= {31'h0, unit_en};
				vmac_pkg::REG_STATUS:
					s_axi_rdata_o <= {10'h0, last_opcode, mul_count};
				default:
				begin
					s_axi_rdata_o <= 32'h0;
					s_axi_rresp_o <= vmac_pkg::RESP_SLVERR;
				end
			endcase
		end
		else if (s_axi_rvalid_o)
		begin
			// Hold the answer until the master takes it
			if (s_axi_rready_i)
			begin
				s_axi_rvalid_o  <= 1'b0;
				s_axi_arready_o <= 1'b1;
			end
		end
		else
			s_axi_arready_o <= 1'b1;
	end

endmodule

// *** vmac_unit_assertions.sv ***
// Checker for the issue and write-back ports of the multiply unit.
// Bound into vmac_unit; judges cause and register of every write-back, lane 0 data of whole-vector loads in formats 001 and 100 to 111 only.
`timescale 1ns/1ns
module vmac_unit_checker
(
	// Clock and reset
	input wire logic                     ref_clk_i,
	input wire logic                     rst_i,
	// Issue and write-back
	input wire logic                     issue_valid_i,
	input wire vmac_pkg::vmac_instr_type issue_instr_i,
	input wire logic [127:0]             first_source_i,
	input wire logic [127:0]             second_source_i,
	input wire logic                     wb_valid_o,
	input wire vmac_pkg::vmac_wb_type    wb_o
);
	logic [15:0]        s0;
	logic [15:0]        t0;
	logic [15:0]        res0;
	logic [15:0]        hs;
	logic [5:0]         op;
	logic               ld0;
	logic signed [31:0] hp;
	logic [31:0]        up;
	logic [31:0]        mp;

	// Lane 0 reference products; broadcasts are left to the bench
	assign s0 = first_source_i[15:0];
	assign t0 = second_source_i[15:0];
	assign res0 = wb_o.data[15:0];
	assign op = issue_instr_i.opcode;
	assign ld0 = issue_valid_i && issue_instr_i.element == 4'h0;
	assign hp = $signed(s0) * $signed(t0);
	assign up = {16'h0, s0} * {16'h0, t0};
	assign mp = $signed({s0[15], s0}) * $signed({1'b0, t0});
	assign hs = (hp > 32'sd32767) ? 16'h7fff :
		(hp < -32'sd32768) ? 16'h8000 : hp[15:0];

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	property p_wb_cause;
		wb_valid_o |-> $past(issue_valid_i) && $past(op[5:4]) == 2'h0;
	endproperty
	a_wb_cause: assert property (p_wb_cause)
		else $error("write-back without a multiply issue");
	property p_refuse;
		issue_valid_i && op[5:4] != 2'h0 |=> !wb_valid_o;
	endproperty
	a_refuse: assert property (p_refuse)
		else $error("write-back after a non-multiply opcode");
	property p_dest;
		wb_valid_o |-> wb_o.dest_vector_reg ==
			$past(issue_instr_i.dest_vector_reg);
	endproperty
	a_dest: assert property (p_dest)
		else $error("write-back register number wrong");
	property p_high;
		wb_valid_o && $past(ld0 && op == 6'h07) |-> res0 == $past(hs);
	endproperty
	a_high: assert property (p_high)
		else $error("high product result wrong");
	property p_frac_u;
		wb_valid_o && $past(ld0 && op == 6'h01 && (s0[15] ^ t0[15])
			&& s0 != 16'h0 && t0 != 16'h0) |-> res0 == 16'h0000;
	endproperty
	a_frac_u: assert property (p_frac_u)
		else $error("negative unsigned fraction not clamped");
	property p_low;
		wb_valid_o && $past(ld0 && op == 6'h04) |-> res0 == $past(up[31:16]);
	endproperty
	a_low: assert property (p_low)
		else $error("low partial product wrong");
	property p_mid;
		wb_valid_o && $past(ld0 && op == 6'h05) |-> res0 == $past(mp[31:16]);
	endproperty
	a_mid: assert property (p_mid)
		else $error("signed by unsigned result wrong");
	property p_mid_us;
		wb_valid_o && $past(ld0 && op == 6'h06 && t0 == 16'h0001)
			|-> res0 == $past(s0);
	endproperty
	a_mid_us: assert property (p_mid_us)
		else $error("unsigned by signed result wrong");
endmodule

bind vmac_unit vmac_unit_checker vmac_unit_checker_inst
(
	.ref_clk_i(ref_clk_i), .rst_i(rst_i), .issue_valid_i(issue_valid_i),
	.issue_instr_i(issue_instr_i), .first_source_i(first_source_i),
	.second_source_i(second_source_i), .wb_valid_o(wb_valid_o), .wb_o(wb_o)
);

// *** vmac_issue_model.sv ***
// Model of the decoder and vector register file facing the unit.
// Assumes the unit takes an issue on a rising edge of ref_clk_i.
`timescale 1ns/1ns
module vmac_issue_model
(
	// Clock
	input  wire logic                     ref_clk_i,
	// Issue to the unit
	output logic                          issue_valid_o,
	output vmac_pkg::vmac_instr_type      issue_instr_o,
	output logic [127:0]                  first_source_o,
	output logic [127:0]                  second_source_o,
	// Write-back from the unit
	input  wire logic                     wb_valid_i,
	input  wire vmac_pkg::vmac_wb_type    wb_i
);
	int                    wb_count = 0;
	vmac_pkg::vmac_wb_type last_wb;

	// Quiet issue port at time zero
	initial
	begin
		issue_valid_o = 1'b0;
		issue_instr_o = '0;
		first_source_o = '0;
		second_source_o = '0;
	end

	// Register file side keeps the last written vector
	always @(posedge ref_clk_i)
	begin
		if (wb_valid_i)
		begin
			last_wb <= wb_i;
			wb_count <= wb_count + 1;
		end
	end

	// One-cycle issue; operands inverted after so stale data never helps
	task automatic issue(input vmac_pkg::vmac_instr_type ins,
		input logic [127:0] a, input logic [127:0] b);
		@(posedge ref_clk_i);
		issue_valid_o <= 1'b1;
		issue_instr_o <= ins;
		first_source_o <= a;
		second_source_o <= b;
		@(posedge ref_clk_i);
		issue_valid_o <= 1'b0;
		first_source_o <= ~a;
		second_source_o <= ~b;
	endtask
endmodule

// *** vmac_unit_test.sv ***
// Self-checking bench for the vector multiply unit.
// Assumes the issue model and the checker files are compiled first.
`timescale 1ns/1ns
module vmac_unit_test;
	logic                     ref_clk_i = 1'b0;
	logic                     rst_i = 1'b1;
	logic                     issue_valid;
	vmac_pkg::vmac_instr_type issue_instr;
	logic [127:0]             src_a;
	logic [127:0]             src_b;
	logic                     wb_valid;
	vmac_pkg::vmac_wb_type    wb;
	logic                     awvalid = 1'b0;
	logic                     wvalid = 1'b0;
	logic                     bready = 1'b0;
	logic                     arvalid = 1'b0;
	logic                     rready = 1'b0;
	logic [7:0]               awaddr = 8'h00;
	logic [7:0]               araddr = 8'h00;
	logic [31:0]              wdata = 32'h0;
	logic                     awready, wready, bvalid, arready, rvalid;
	logic [1:0]               bresp, rresp;
	logic [31:0]              rdata;
	logic [3:0]               els [5] = '{4'h0, 4'h3, 4'h6, 4'hb, 4'h1};
	int                       err_count = 0;
	int                       check_count = 0;
	int                       n_mul = 0;

	// Free-running core clock
	always #5 ref_clk_i = ~ref_clk_i;

	vmac_unit vmac_unit_inst
	(
		.ref_clk_i(ref_clk_i), .rst_i(rst_i), .issue_valid_i(issue_valid),
		.issue_instr_i(issue_instr), .first_source_i(src_a),
		.second_source_i(src_b), .wb_valid_o(wb_valid), .wb_o(wb),
		.s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_awaddr_i(awaddr), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(4'hf), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_bresp_o(bresp),
		.s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
		.s_axi_araddr_i(araddr), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready), .s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp)
	);

	vmac_issue_model vmac_issue_model_inst
	(
		.ref_clk_i(ref_clk_i), .issue_valid_o(issue_valid),
		.issue_instr_o(issue_instr), .first_source_o(src_a),
		.second_source_o(src_b), .wb_valid_i(wb_valid), .wb_i(wb)
	);

	// Verdict in one place
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Compare a vector result
	task automatic chk_vec(input string n, input logic [127:0] e,
		input logic [127:0] g);
		check_count++;
		if (g !== e)
		begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask

	// Compare a word, response code or count
	task automatic chk_word(input string n, input logic [31:0] e,
		input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask

	// A wait that ran out is a mismatch
	task automatic fail_wait();
		err_count++;
		$display("[FAIL] handshake expected done seen timeout");
		report_and_stop();
	endtask

	// Write: address and data offered together, bready held
	task automatic axi_wr(input logic [7:0] ad, input logic [31:0] d,
		input logic [1:0] r);
		@(posedge ref_clk_i);
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		awaddr <= ad;
		wdata <= d;
		bready <= 1'b1;
		for (int n = 0; n < 20; n++)
		begin
			@(posedge ref_clk_i);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			if (bvalid)
			begin
				bready <= 1'b0;
				chk_word("bresp", 32'(r), 32'(bresp));
				return;
			end
		end
		fail_wait();
	endtask

	// Read with rready held until the answer
	task automatic axi_rd(input logic [7:0] ad, input logic [31:0] e,
		input logic [1:0] r);
		@(posedge ref_clk_i);
		arvalid <= 1'b1;
		araddr <= ad;
		rready <= 1'b1;
		for (int n = 0; n < 20; n++)
		begin
			@(posedge ref_clk_i);
			if (arready)
				arvalid <= 1'b0;
			if (rvalid)
			begin
				rready <= 1'b0;
				chk_word("rdata", e, rdata);
				chk_word("rresp", 32'(r), 32'(rresp));
				return;
			end
		end
		fail_wait();
	endtask

	// Issue, then allow the fixed one-cycle write-back latency to land
	task automatic mul(input logic [5:0] op, input logic [3:0] el,
		input logic [4:0] s1, input logic [127:0] a, input logic [127:0] b,
		input bit w);
		int n;
		n = vmac_issue_model_inst.wb_count;
		vmac_issue_model_inst.issue({op, el, 5'h2, s1, 5'h3}, a, b);
		repeat (3) @(posedge ref_clk_i);
		chk_word("wb count", 32'(w), 32'(vmac_issue_model_inst.wb_count - n));
		if (w)
			n_mul++;
		if (w)
			chk_word("dest", 32'h3,
				32'(vmac_issue_model_inst.last_wb.dest_vector_reg));
	endtask

	// Same operands and same expected result in every lane
	task automatic run(input logic [5:0] op, input logic [4:0] s1,
		input logic [15:0] s, input logic [15:0] t, input logic [15:0] e);
		mul(op, 4'h0, s1, {8{s}}, {8{t}}, 1'b1);
		chk_vec("lanes", {8{e}}, vmac_issue_model_inst.last_wb.data);
	endtask

	// Lane picked by an element code for lane i
	function automatic int pick(input logic [3:0] el, input int i);
		if (el[3])
			return el[2:0];
		if (el[2])
			return (i & 4) | el[1:0];
		if (el[1])
			return (i & 6) | el[0];
		return i;
	endfunction

	// Main sequence
	initial
	begin
		logic [127:0] a, b, e;
		repeat (20) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		axi_rd(vmac_pkg::REG_CTRL, 32'h1, vmac_pkg::RESP_OKAY);
		run(6'h00, 5'h0, 16'h4000, 16'h4000, 16'h2000);
		run(6'h08, 5'h0, 16'h4000, 16'h4000, 16'h4000);
		run(6'h08, 5'h0, 16'h4000, 16'h4000, 16'h6000);
		run(6'h08, 5'h0, 16'h4000, 16'h4000, 16'h7fff);
		run(6'h01, 5'h0, 16'h8000, 16'h4000, 16'h0000);
		run(6'h01, 5'h0, 16'h4000, 16'h4000, 16'h2000);
		run(6'h09, 5'h0, 16'h7fff, 16'h7fff, 16'h9ffe);
		run(6'h09, 5'h0, 16'h7fff, 16'h7fff, 16'hffff);
		run(6'h07, 5'h0, 16'h0003, 16'h0005, 16'h000f);
		run(6'h02, 5'h1, 16'h0000, 16'h0001, 16'h0010);
		run(6'h0a, 5'h1, 16'h0000, 16'h0001, 16'h0010);
		run(6'h02, 5'h0, 16'h0000, 16'h0001, 16'h0010);
		run(6'h07, 5'h0, 16'hfffd, 16'h0005, 16'hfff1);
		run(6'h0a, 5'h1, 16'h0000, 16'h0001, 16'hfff2);
		run(6'h03, 5'h0, 16'h0010, 16'h0010, 16'h0080);
		run(6'h0b, 5'h0, 16'h1234, 16'h5678, 16'h0070);
		run(6'h03, 5'h0, 16'hfff0, 16'h0010, 16'hff80);
		run(6'h0b, 5'h0, 16'h1234, 16'h5678, 16'hff90);
		run(6'h00, 5'h0, 16'h0001, 16'h0001, 16'h0000);
		run(6'h0b, 5'h0, 16'h1234, 16'h5678, 16'h0000);
		run(6'h04, 5'h0, 16'hffff, 16'hffff, 16'hfffe);
		run(6'h05, 5'h0, 16'hffff, 16'hffff, 16'hffff);
		run(6'h06, 5'h0, 16'hffff, 16'h0001, 16'hffff);
		// Broadcast codes: whole vector, quarter, half, whole, odd zero
		foreach (els[k])
		begin
			for (int i = 0; i < 8; i++)
			begin
				a[16*i +: 16] = 16'(i + 1);
				b[16*i +: 16] = 16'(i + 1);
				e[16*i +: 16] = 16'((i + 1) * (pick(els[k], i) + 1));
			end
			mul(6'h07, els[k], 5'h0, a, b, 1'b1);
			chk_vec("broadcast", e, vmac_issue_model_inst.last_wb.data);
		end
		mul(6'h10, 4'h0, 5'h0, a, b, 1'b0);
		axi_wr(vmac_pkg::REG_CTRL, 32'h0, vmac_pkg::RESP_OKAY);
		mul(6'h07, 4'h0, 5'h0, a, b, 1'b0);
		axi_wr(vmac_pkg::REG_CTRL, 32'h1, vmac_pkg::RESP_OKAY);
		axi_wr(vmac_pkg::REG_STATUS, 32'h0, vmac_pkg::RESP_SLVERR);
		axi_rd(8'h08, 32'h0, vmac_pkg::RESP_SLVERR);
		axi_rd(vmac_pkg::REG_STATUS, {10'h0, 6'h07, 16'(n_mul)},
			vmac_pkg::RESP_OKAY);
		report_and_stop();
	end
endmodule
